// ==== hw/ihps_pkg.sv ====
// Package of widths, decode constants and timing counts for the ISA host port
package ihps_pkg;
    localparam int ADDR_W        = 12;
    localparam int DATA_W        = 8;
    localparam int REG_SEL_W     = 3;
    // Address bits compared against the serial-port emulation base
    localparam int COM_HI_MSB    = 9;
    localparam int COM_HI_LSB    = 3;
    // Address bits reserved for the plug-and-play decoder only
    localparam int PNP_HI_MSB    = 11;
    localparam int PNP_HI_LSB    = 10;
    localparam logic [6:0] COM_BASE_RST   = 7'h7F;  // 0x3F8 >> 3
    localparam logic [9:0] MBOX_ADDR_RST  = 10'h2F0;
    localparam logic [11:0] PNP_ADDR_RST  = 12'hA79;
    // Host strobe width in ns and in cycles
    localparam int STROBE_NS     = 120;
    localparam int CLK_NS        = 4;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 8;
endpackage

// ==== hw/ihps_if.sv ====
// Interface joining the device end and the host end of the ISA host port
`timescale 1ns/1ns
interface ihps_if;
    import ihps_pkg::*;
    logic [ADDR_W-1:0] host_addr_in;
    logic              host_addr_qualify_n;
    logic              host_write_strobe_n;
    logic              host_read_strobe_n;
    logic [DATA_W-1:0] host_data_h2d;
    logic              host_data_h2d_oe;
    logic [DATA_W-1:0] host_data_d2h;
    logic              host_read_drive_enable_n;
    logic              host_irq_out_a;
    logic              host_irq_out_a_oe;
    logic              host_irq_out_b;
    logic              host_irq_out_b_oe;
    logic              host_dma_req_a;
    logic              host_dma_req_a_oe;
    logic              host_dma_req_b;
    logic              host_dma_req_b_oe;
    logic              host_dma_ack_n_a;
    logic              host_dma_ack_n_b;
    modport dev (
        input  host_addr_in, host_addr_qualify_n, host_write_strobe_n,
        input  host_read_strobe_n, host_data_h2d, host_data_h2d_oe,
        input  host_dma_ack_n_a, host_dma_ack_n_b,
        output host_data_d2h, host_read_drive_enable_n,
        output host_irq_out_a, host_irq_out_a_oe, host_irq_out_b, host_irq_out_b_oe,
        output host_dma_req_a, host_dma_req_a_oe, host_dma_req_b, host_dma_req_b_oe
    );
    modport host (
        output host_addr_in, host_addr_qualify_n, host_write_strobe_n,
        output host_read_strobe_n, host_data_h2d, host_data_h2d_oe,
        output host_dma_ack_n_a, host_dma_ack_n_b,
        input  host_data_d2h, host_read_drive_enable_n,
        input  host_irq_out_a, host_irq_out_a_oe, host_irq_out_b, host_irq_out_b_oe,
        input  host_dma_req_a, host_dma_req_a_oe, host_dma_req_b, host_dma_req_b_oe
    );
endinterface

// ==== hw/ihps_dev.sv ====
// Device end of the ISA host port: decode, read drive, interrupt and DMA request
`timescale 1ns/1ns
// Behaviour
// - Drive enable low during emulation, mailbox, PnP reads
// - Drive enable low during host DMA reads
// - Address bits 2-0 select emulation register
// - Bits 11-10 used by PnP decode only
// - Address matches only while qualify is low
// - Host gates bits 15-12 into qualify
// - Host writes with write strobe low
// - Host reads with read strobe low
// - One interrupt output driven, other released; both released in reset
// - DMA requested on one of two outputs
// - Host acknowledges low while moving data
module ihps_dev #(
    parameter logic [6:0]  COM_BASE  = ihps_pkg::COM_BASE_RST,
    parameter logic [9:0]  MBOX_ADDR = ihps_pkg::MBOX_ADDR_RST,
    parameter logic [11:0] PNP_ADDR  = ihps_pkg::PNP_ADDR_RST
) (
    input  wire logic                         sys_clk_i,
    input  wire logic                         nrst_i,
    ihps_if.dev                               bus,
    input  wire logic                         irq_req_i,
    input  wire logic                         irq_sel_b_i,
    input  wire logic                         dma_req_i,
    input  wire logic                         dma_sel_b_i,
    input  wire logic                         dma_dir_read_i,
    input  wire logic [ihps_pkg::DATA_W-1:0]  rd_data_i,
    output logic [ihps_pkg::REG_SEL_W-1:0]    reg_sel_o,
    output logic [ihps_pkg::DATA_W-1:0]       wr_data_o,
    output logic                              com_wr_o,
    output logic                              com_rd_o,
    output logic                              mbox_wr_o,
    output logic                              pnp_wr_o,
    output logic                              dma_wr_o,
    output logic                              dma_rd_o
);
    import ihps_pkg::*;

    // --------------------------------------------------------------
    // Decode helper
    // --------------------------------------------------------------
    // One qualified address-field compare, shared by the three decoders
    function automatic logic field_hit(input logic              q,
                                       input logic [ADDR_W-1:0] got,
                                       input logic [ADDR_W-1:0] want);
        field_hit = q && (got == want);
    endfunction

    // --------------------------------------------------------------
    // Address decode
    // --------------------------------------------------------------
    wire logic [ADDR_W-1:0] addr    = bus.host_addr_in;
    wire logic              qual    = ~bus.host_addr_qualify_n;
    // Upper two bits reach the plug-and-play compare only
    wire logic [ADDR_W-1:0] com_fld = {5'h00, addr[COM_HI_MSB:COM_HI_LSB]};
    wire logic [ADDR_W-1:0] mbx_fld = {2'b00, addr[PNP_HI_LSB-1:0]};
    wire logic [ADDR_W-1:0] com_ref = {5'h00, COM_BASE};
    wire logic [ADDR_W-1:0] mbx_ref = {2'b00, MBOX_ADDR};
    wire logic              com_hit = field_hit(qual, com_fld, com_ref);
    wire logic              mbx_hit = field_hit(qual, mbx_fld, mbx_ref);
    wire logic              pnp_hit = field_hit(qual, addr, PNP_ADDR);
    wire logic              any_hit = com_hit || mbx_hit || pnp_hit;

    // --------------------------------------------------------------
    // Strobes and grant
    // --------------------------------------------------------------
    wire logic rd_n         = bus.host_read_strobe_n;
    wire logic wr_n         = bus.host_write_strobe_n;
    wire logic ack_any      = ~bus.host_dma_ack_n_a || ~bus.host_dma_ack_n_b;
    wire logic io_rd        = ~rd_n && any_hit;
    wire logic dma_rd       = ack_any && dma_dir_read_i && ~rd_n;
    wire logic next_drive_n = ~(io_rd || dma_rd);

    logic              rd_n_d;
    logic              wr_n_d;
    logic              drive_n;
    logic [DATA_W-1:0] rd_q;
    logic              com_q;
    logic              mbx_q;
    logic              pnp_q;
    logic              ack_q;

    // Target and grant are held from the strobe's low phase: the host may
    // lift its address enable and acknowledge on the edge that ends a write
    wire logic              next_com_q   = wr_n ? com_q : com_hit;
    wire logic              next_mbx_q   = wr_n ? mbx_q : mbx_hit;
    wire logic              next_pnp_q   = wr_n ? pnp_q : pnp_hit;
    wire logic              next_ack_q   = wr_n ? ack_q : ack_any;
    // Write data is taken only while the host drives the bus
    wire logic              take_data    = ~wr_n && bus.host_data_h2d_oe;
    wire logic [DATA_W-1:0] next_wr_data = take_data ? bus.host_data_h2d : wr_data_o;
    wire logic              wr_end       = ~wr_n_d && wr_n;
    wire logic              rd_beg       = rd_n_d && ~rd_n;

    // --------------------------------------------------------------
    // Strobe history
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_n_d <= 1'b1;
            wr_n_d <= 1'b1;
        end else begin
            rd_n_d <= rd_n;
            wr_n_d <= wr_n;
        end
    end

    // --------------------------------------------------------------
    // Read drive
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            drive_n <= 1'b1;
            rd_q    <= 8'h00;
        end else begin
            drive_n <= next_drive_n;
            rd_q    <= rd_data_i;
        end
    end
    assign bus.host_read_drive_enable_n = drive_n;
    assign bus.host_data_d2h            = rd_q;

    // --------------------------------------------------------------
    // Write target capture
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            com_q <= 1'b0;
            mbx_q <= 1'b0;
            pnp_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            com_q <= next_com_q;
            mbx_q <= next_mbx_q;
            pnp_q <= next_pnp_q;
            ack_q <= next_ack_q;
        end
    end

    // --------------------------------------------------------------
    // Register select and write data
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_sel_o <= 3'h0;
            wr_data_o <= 8'h00;
        end else begin
            reg_sel_o <= addr[REG_SEL_W-1:0];
            wr_data_o <= next_wr_data;
        end
    end

    // --------------------------------------------------------------
    // User-side strobes
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            com_wr_o  <= 1'b0;
            com_rd_o  <= 1'b0;
            mbox_wr_o <= 1'b0;
            pnp_wr_o  <= 1'b0;
            dma_wr_o  <= 1'b0;
            dma_rd_o  <= 1'b0;
        end else begin
            com_wr_o  <= wr_end && com_q;
            com_rd_o  <= rd_beg && com_hit;
            mbox_wr_o <= wr_end && mbx_q;
            pnp_wr_o  <= wr_end && pnp_q;
            dma_wr_o  <= wr_end && ack_q && !dma_dir_read_i;
            dma_rd_o  <= rd_beg && ack_any && dma_dir_read_i;
        end
    end

    // --------------------------------------------------------------
    // Interrupt pins
    // --------------------------------------------------------------
    logic irq_a;
    logic irq_b;
    logic irq_a_oe;
    logic irq_b_oe;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_a    <= 1'b0;
            irq_b    <= 1'b0;
            irq_a_oe <= 1'b0;
            irq_b_oe <= 1'b0;
        end else begin
            irq_a_oe <= !irq_sel_b_i;
            irq_b_oe <= irq_sel_b_i;
            irq_a    <= irq_req_i && !irq_sel_b_i;
            irq_b    <= irq_req_i && irq_sel_b_i;
        end
    end
    assign bus.host_irq_out_a    = irq_a;
    assign bus.host_irq_out_b    = irq_b;
    assign bus.host_irq_out_a_oe = irq_a_oe;
    assign bus.host_irq_out_b_oe = irq_b_oe;

    // --------------------------------------------------------------
    // DMA request pins
    // --------------------------------------------------------------
    logic drq_a;
    logic drq_b;
    logic drq_a_oe;
    logic drq_b_oe;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            drq_a    <= 1'b0;
            drq_b    <= 1'b0;
            drq_a_oe <= 1'b0;
            drq_b_oe <= 1'b0;
        end else begin
            drq_a_oe <= !dma_sel_b_i;
            drq_b_oe <= dma_sel_b_i;
            drq_a    <= dma_req_i && !dma_sel_b_i;
            drq_b    <= dma_req_i && dma_sel_b_i;
        end
    end
    assign bus.host_dma_req_a    = drq_a;
    assign bus.host_dma_req_b    = drq_b;
    assign bus.host_dma_req_a_oe = drq_a_oe;
    assign bus.host_dma_req_b_oe = drq_b_oe;
endmodule

// ==== hw/ihps_host.sv ====
// Host end of the ISA host port: I/O cycles and DMA acknowledge
`timescale 1ns/1ns
module ihps_host (
    input  wire logic                         sys_clk_i,
    input  wire logic                         nrst_i,
    ihps_if.host                              bus,
    input  wire logic                         io_req_i,
    input  wire logic                         io_write_i,
    input  wire logic [15:0]                  io_addr_i,
    input  wire logic [ihps_pkg::DATA_W-1:0]  io_wdata_i,
    input  wire logic                         dma_en_i,
    input  wire logic                         dma_write_i,
    output logic                              busy_o,
    output logic                              done_o,
    output logic [ihps_pkg::DATA_W-1:0]       rdata_o,
    output logic                              irq_o
);
    import ihps_pkg::*;

    typedef enum logic [1:0] {IHPS_IDLE, IHPS_IO, IHPS_DMA} ihps_state_e;
    ihps_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic aen_n, wr_n, rd_n, dout_oe, ack_a, ack_b;
    logic [DATA_W-1:0] dout;

    wire logic req_a  = bus.host_dma_req_a_oe && bus.host_dma_req_a;
    wire logic req_b  = bus.host_dma_req_b_oe && bus.host_dma_req_b;
    wire logic cnt_end = (cnt == CNT_W'(STROBE_CYC - 1));
    // External high-bit decode folded into the qualify line
    wire logic hi_zero = (io_addr_i[15:12] == 4'h0);

    // --------------------------------------------------------------
    // Cycle engine
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st      <= IHPS_IDLE;
            cnt     <= '0;
            addr    <= '0;
            aen_n   <= 1'b1;
            wr_n    <= 1'b1;
            rd_n    <= 1'b1;
            dout_oe <= 1'b0;
            dout    <= 8'h00;
            ack_a   <= 1'b0;
            ack_b   <= 1'b0;
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
            rdata_o <= 8'h00;
            irq_o   <= 1'b0;
        end else begin
            done_o <= 1'b0;
            irq_o  <= (bus.host_irq_out_a_oe && bus.host_irq_out_a) ||
                      (bus.host_irq_out_b_oe && bus.host_irq_out_b);
            case (st)
            IHPS_IDLE: begin
                cnt <= '0;
                if (io_req_i) begin
                    st      <= IHPS_IO;
                    busy_o  <= 1'b1;
                    addr    <= io_addr_i[ADDR_W-1:0];
                    aen_n   <= !hi_zero;
                    wr_n    <= !io_write_i;
                    rd_n    <= io_write_i;
                    dout_oe <= io_write_i;
                    dout    <= io_wdata_i;
                end else if (dma_en_i && (req_a || req_b)) begin
                    st      <= IHPS_DMA;
                    busy_o  <= 1'b1;
                    ack_a   <= req_a;
                    ack_b   <= !req_a;
                    wr_n    <= !dma_write_i;
                    rd_n    <= dma_write_i;
                    dout_oe <= dma_write_i;
                    dout    <= io_wdata_i;
                end
            end
            default: begin
                cnt <= cnt + 1'b1;
                if (cnt_end) begin
                    if (!rd_n) begin
                        rdata_o <= bus.host_data_d2h;
                    end
                    st      <= IHPS_IDLE;
                    busy_o  <= 1'b0;
                    done_o  <= 1'b1;
                    aen_n   <= 1'b1;
                    wr_n    <= 1'b1;
                    rd_n    <= 1'b1;
                    dout_oe <= 1'b0;
                    ack_a   <= 1'b0;
                    ack_b   <= 1'b0;
                end
            end
            endcase
        end
    end

    assign bus.host_addr_in        = addr;
    assign bus.host_addr_qualify_n = aen_n;
    assign bus.host_write_strobe_n = wr_n;
    assign bus.host_read_strobe_n  = rd_n;
    // A released data bus shows the inverse of the last byte
    assign bus.host_data_h2d       = dout_oe ? dout : ~dout;
    assign bus.host_data_h2d_oe    = dout_oe;
    assign bus.host_dma_ack_n_a    = !ack_a;
    assign bus.host_dma_ack_n_b    = !ack_b;
endmodule

// ==== tb/ihps_monitor.sv ====
// Checker of the signals between the two ends of the ISA host port
`timescale 1ns/1ns
module ihps_monitor
    import ihps_pkg::*;
(
    input wire logic              sys_clk_i,
    input wire logic              nrst_i,
    input wire logic [ADDR_W-1:0] host_addr_in,
    input wire logic              host_addr_qualify_n,
    input wire logic              host_read_strobe_n,
    input wire logic              host_read_drive_enable_n,
    input wire logic              host_dma_ack_n_a,
    input wire logic              host_dma_ack_n_b,
    input wire logic              host_irq_out_a,
    input wire logic              host_irq_out_a_oe,
    input wire logic              host_irq_out_b,
    input wire logic              host_irq_out_b_oe,
    input wire logic              host_dma_req_a_oe,
    input wire logic              host_dma_req_b_oe
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // ------------------------------
    // Qualified read decode
    // ------------------------------
    wire q_rd   = !host_addr_qualify_n && !host_read_strobe_n;
    wire com_rd = q_rd && host_addr_in[COM_HI_MSB:COM_HI_LSB] == COM_BASE_RST;
    wire mbx_rd = q_rd && host_addr_in[9:0] == MBOX_ADDR_RST;
    wire pnp_rd = q_rd && host_addr_in == PNP_ADDR_RST;
    wire hi_bad = q_rd && host_addr_in[9:0] == PNP_ADDR_RST[9:0]
                  && host_addr_in[PNP_HI_MSB:PNP_HI_LSB] != PNP_ADDR_RST[11:10];
    wire dma_rd = !host_read_strobe_n && !(host_dma_ack_n_a && host_dma_ack_n_b);
    wire any_rd = com_rd || mbx_rd || pnp_rd;
    wire irq_hi = host_irq_out_a || host_irq_out_b;
    wire irq_ok = host_irq_out_a ? host_irq_out_a_oe && !host_irq_out_b : host_irq_out_b_oe;
    sequence s_drive;
        !host_read_drive_enable_n;
    endsequence
    a_read_drive: assert property (any_rd |=> s_drive)
        else $error("read hit without data drive");
    a_dma_drive: assert property (dma_rd |=> s_drive)
        else $error("dma read without data drive");
    a_no_stray: assert property (!host_read_drive_enable_n |-> $past(any_rd || dma_rd))
        else $error("data drive without qualified read");
    a_pnp_hi_bits: assert property (hi_bad |=> host_read_drive_enable_n)
        else $error("plug-and-play upper bits ignored");
    a_drive_release: assert property (host_read_strobe_n |=> host_read_drive_enable_n)
        else $error("data drive held after strobe");
    a_irq_one_pin: assert property (!(host_irq_out_a_oe && host_irq_out_b_oe))
        else $error("both interrupt pins driven");
    a_irq_drive_high: assert property (irq_hi |-> irq_ok)
        else $error("high interrupt pin not driven alone");
    a_dma_one_pin: assert property (!(host_dma_req_a_oe && host_dma_req_b_oe))
        else $error("both dma request pins driven");
endmodule

// ==== tb/tb.sv ====
// Self-checking bench joining the device and host ends of the ISA host port
`timescale 1ns/1ns
module tb;
    import ihps_pkg::*;
    localparam int LIMIT = 3000;
    logic        sys_clk_i, nrst_i, io_req_i, io_write_i, dma_en_i, dma_write_i;
    logic        irq_req_i, irq_sel_b_i, dma_req_i, dma_sel_b_i, dma_dir_read_i;
    logic [15:0] io_addr_i;
    logic [7:0]  io_wdata_i, rd_data_i, rd_cap, cap_dat, wr_data_o, rdata_o;
    logic [2:0]  reg_sel_o, cap_sel;
    logic        busy_o, done_o, irq_o;
    logic [6:0]  seen;
    logic        clr_seen;
    wire  [5:0]  pul;
    int          n_errors, checks_done, cyc;
    ihps_if bus();
    wire  [1:0]  dreq = {bus.host_dma_req_b_oe & bus.host_dma_req_b,
                         bus.host_dma_req_a_oe & bus.host_dma_req_a};
    ihps_dev ihps_dev_inst (.sys_clk_i, .nrst_i, .bus, .irq_req_i, .irq_sel_b_i,
        .dma_req_i, .dma_sel_b_i, .dma_dir_read_i, .rd_data_i, .reg_sel_o, .wr_data_o,
        .com_wr_o(pul[0]), .com_rd_o(pul[1]), .mbox_wr_o(pul[2]), .pnp_wr_o(pul[3]),
        .dma_wr_o(pul[4]), .dma_rd_o(pul[5]));
    ihps_host ihps_host_inst (.sys_clk_i, .nrst_i, .bus, .io_req_i, .io_write_i,
        .io_addr_i, .io_wdata_i, .dma_en_i, .dma_write_i, .busy_o, .done_o, .rdata_o, .irq_o);
    ihps_monitor ihps_monitor_inst (.sys_clk_i, .nrst_i,
        .host_addr_in(bus.host_addr_in), .host_addr_qualify_n(bus.host_addr_qualify_n),
        .host_read_strobe_n(bus.host_read_strobe_n),
        .host_read_drive_enable_n(bus.host_read_drive_enable_n),
        .host_dma_ack_n_a(bus.host_dma_ack_n_a), .host_dma_ack_n_b(bus.host_dma_ack_n_b),
        .host_irq_out_a(bus.host_irq_out_a), .host_irq_out_a_oe(bus.host_irq_out_a_oe),
        .host_irq_out_b(bus.host_irq_out_b), .host_irq_out_b_oe(bus.host_irq_out_b_oe),
        .host_dma_req_a_oe(bus.host_dma_req_a_oe), .host_dma_req_b_oe(bus.host_dma_req_b_oe));
    // ------------------------------
    // Clock, pulse capture, timeout
    // ------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        seen <= clr_seen ? 7'h00 : (seen | {!bus.host_read_drive_enable_n, pul});
        if (pul[0] || pul[1]) cap_sel <= reg_sel_o;
        if (pul[0] || pul[2] || pul[3] || pul[4]) cap_dat <= wr_data_o;
        if (cyc == LIMIT) begin
            close_out();
        end
    end
    // A run that reaches the cycle limit counts one mismatch
    task automatic close_out();
        int errs;
        errs = n_errors + ((cyc >= LIMIT) ? 1 : 0);
        $display("checks %0d mismatches %0d", checks_done, errs);
        if (errs == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits for the host to finish, then keeps its read data
    task automatic settle();
        for (int i = 0; i < 100 && done_o !== 1'b1; i++) @(negedge sys_clk_i);
        chk({6'h0, busy_o, done_o}, 8'h01);
        rd_cap = rdata_o;
    endtask
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] exp);
        @(negedge sys_clk_i);
        clr_seen = 1'b1;
        io_write_i = wr;
        io_addr_i = a;
        io_wdata_i = 8'h3C ^ a[7:0];
        io_req_i = 1'b1;
        @(negedge sys_clk_i);
        io_req_i = 1'b0;
        clr_seen = 1'b0;
        chk({7'h0, busy_o}, 8'h01);
        settle();
        repeat (3) @(negedge sys_clk_i);
        chk({1'b0, seen}, exp);
    endtask
    initial begin
        {nrst_i, io_req_i, io_write_i, dma_en_i, dma_write_i} = '0;
        {irq_req_i, irq_sel_b_i, dma_req_i, dma_sel_b_i, dma_dir_read_i} = '0;
        io_addr_i = '0;
        io_wdata_i = '0;
        rd_data_i = 8'h5C;
        clr_seen = 1'b1;
        repeat (16) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            io(1'b1, 16'h03F8 + 16'(i), 8'h01);
            chk({5'h0, cap_sel}, 8'(i));
            chk(cap_dat, 8'h3C ^ (8'hF8 + 8'(i)));
        end
        $display("test register writes done");
        io(1'b0, 16'h03FD, 8'h42);
        chk(rd_cap, 8'h5C);
        chk({5'h0, cap_sel}, 8'h05);
        io(1'b1, 16'h02F0, 8'h04);
        io(1'b1, 16'h0A79, 8'h08);
        io(1'b1, 16'h07F8, 8'h01);
        io(1'b1, 16'h0279, 8'h00);
        io(1'b1, 16'h13F8, 8'h00);
        io(1'b0, 16'h02F0, 8'h40);
        io(1'b0, 16'h0A79, 8'h40);
        io(1'b0, 16'h0279, 8'h00);
        io(1'b0, 16'h13FD, 8'h00);
        $display("test decode done");
        for (int s = 0; s < 2; s++) begin
            irq_sel_b_i = s[0];
            irq_req_i = 1'b1;
            repeat (4) @(negedge sys_clk_i);
            chk({5'h0, irq_o, bus.host_irq_out_a_oe, bus.host_irq_out_b_oe},
                s ? 8'h05 : 8'h06);
            irq_req_i = 1'b0;
            repeat (4) @(negedge sys_clk_i);
            chk({7'h0, irq_o}, 8'h00);
        end
        $display("test interrupt done");
        for (int k = 0; k < 4; k++) begin
            dma_sel_b_i = k[0];
            dma_write_i = k[1];
            dma_dir_read_i = !k[1];
            io_wdata_i = 8'hC3;
            clr_seen = 1'b1;
            dma_req_i = 1'b1;
            @(negedge sys_clk_i);
            clr_seen = 1'b0;
            repeat (2) @(negedge sys_clk_i);
            chk({6'h0, dreq}, k[0] ? 8'h02 : 8'h01);
            dma_en_i = 1'b1;
            settle();
            dma_en_i = 1'b0;
            dma_req_i = 1'b0;
            repeat (3) @(negedge sys_clk_i);
            chk({1'b0, seen}, k[1] ? 8'h10 : 8'h60);
            chk(k[1] ? cap_dat : rd_cap, k[1] ? 8'hC3 : 8'h5C);
        end
        $display("test dma done");
        close_out();
    end
endmodule
